/* inc/fdj_pkg.sv */
// Shared constants and types of the frequency supervision and skip block.
// Assumes one 50 MHz core clock and a 32-bit classic Wishbone register bus.
package fdj_pkg;

  // ****************************************************************
  // Frequency format
  // ****************************************************************
  // Frequencies are unsigned counts of 0.01 Hz.
  localparam int FREQ_W = 16;
  typedef logic [FREQ_W-1:0] fdj_freq_t;

  localparam fdj_freq_t FREQ_ZERO     = 16'h0000;
  localparam fdj_freq_t FREQ_SAT      = 16'hFFFF;
  localparam fdj_freq_t LEVEL_RST     = 16'h1388;
  localparam fdj_freq_t HYST_RST      = 16'h00FA;
  localparam fdj_freq_t POINT_RST     = 16'h0000;
  localparam fdj_freq_t HALF_W_RST    = 16'h0000;
  localparam fdj_freq_t HALF_W_MAX    = 16'h01F4;
  localparam fdj_freq_t FMAX_RST      = 16'h1388;
  localparam logic [15:0] HOLD_RST    = 16'h01F4;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic        SKIP_EN_RST = 1'b0;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_CTRL    = 8'h00;
  localparam logic [ADR_W-1:0] ADR_LVL1    = 8'h04;
  localparam logic [ADR_W-1:0] ADR_HYS1    = 8'h08;
  localparam logic [ADR_W-1:0] ADR_LVL2    = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_HYS2    = 8'h10;
  localparam logic [ADR_W-1:0] ADR_PT1     = 8'h14;
  localparam logic [ADR_W-1:0] ADR_PT2     = 8'h18;
  localparam logic [ADR_W-1:0] ADR_HALF_W  = 8'h1C;
  localparam logic [ADR_W-1:0] ADR_FMAX    = 8'h20;
  localparam logic [ADR_W-1:0] ADR_HOLD    = 8'h24;
  localparam logic [ADR_W-1:0] ADR_STATUS  = 8'h28;

  localparam int CTRL_SKIP_BIT   = 0;
  localparam int STAT_FLAG1_BIT  = 16;
  localparam int STAT_FLAG2_BIT  = 17;
  localparam int STAT_STATE_LSB  = 18;
  localparam int NUM_DET         = 2;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Skip state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    JS_PASS,
    JS_HOLD,
    JS_SKIP
  } fdj_jump_e;

endpackage : fdj_pkg

/* inc/fdj_det_if.sv */
// Carrier between the top module and one threshold detector.
// Assumes all members are driven on the core clock.
`timescale 1ns/1ps
interface fdj_det_if;
  fdj_pkg::fdj_freq_t level;
  fdj_pkg::fdj_freq_t hyst;
  fdj_pkg::fdj_freq_t freq;
  logic               flag;

  modport top (output level, output hyst, output freq, input flag);
  modport det (input level, input hyst, input freq, output flag);
endinterface : fdj_det_if

/* src/fdj_thresh.sv */
// One frequency threshold detector with hysteresis on the way down.
// Assumes level, hysteresis and frequency come from the same clock domain.
`timescale 1ns/1ps
module fdj_thresh (
  input  wire logic core_clk,
  input  wire logic rstn,
  fdj_det_if.det    dif
);

  typedef struct packed {
    logic flag;
  } fdj_thr_s;

  fdj_thr_s           st;
  fdj_thr_s           next_st;
  fdj_pkg::fdj_freq_t hys_eff;
  fdj_pkg::fdj_freq_t low_edge;

  // ****************************************************************
  // Detection
  // ****************************************************************
  always_comb begin
    next_st = st;
    // A level lowered below the stored hysteresis must not underflow.
    hys_eff  = (dif.hyst > dif.level) ? dif.level : dif.hyst;
    low_edge = dif.level - hys_eff;
    if (dif.freq > dif.level) begin
      next_st.flag = 1'b1;
    end else if (dif.freq < low_edge) begin
      next_st.flag = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dif.flag = st.flag;

endmodule : fdj_thresh

/* src/fdj_top.sv */
// Frequency supervision top: two threshold flags, two skip bands, Wishbone registers.
// Assumes ramp_freq comes from the ramp generator on core_clk and a classic
// Wishbone master on the same clock.
//
// Functional notes
// - The first flag rises when the running frequency goes above the first level, default 50.00 Hz.
// - The first flag falls only when the running frequency goes below first level minus first hysteresis, default 2.5 Hz.
// - The second flag works independently and rises above the second level, default 50.00 Hz.
// - The second flag falls only below second level minus second hysteresis, default 2.5 Hz.
// - Hysteresis acts only on the way down; on the way up the bare level switches the flag.
// - Levels are held between 0.00 Hz and the maximum frequency, and each hysteresis between zero and its level.
// - There are two skip points, and the skip function is off when both are zero.
// - A skip point set to zero is ignored on its own, and both points reset to 0.00 Hz.
// - Each skipped band is twice the half width wide, which ranges from zero to 5.00 Hz and resets to 0.00 Hz.
// - Accelerating into a band, the output holds its frequency for a while and then steps over the band.
// - Decelerating into a band, the output holds its frequency for a while and then steps down past the band.
// - With the ramp skip option at 0, its reset value, the output runs straight through bands while ramping.
// - With the ramp skip option at 1, the output skips the band whenever a ramp nears a skip point.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module fdj_top (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [fdj_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire fdj_pkg::fdj_freq_t         ramp_freq,
  output fdj_pkg::fdj_freq_t              freq_out,
  output logic                            freq_threshold_one,
  output logic                            freq_threshold_two
);

  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
    logic               skip_while_ramping;
    fdj_pkg::fdj_freq_t threshold_one_level;
    fdj_pkg::fdj_freq_t threshold_one_hysteresis;
    fdj_pkg::fdj_freq_t threshold_two_level;
    fdj_pkg::fdj_freq_t threshold_two_hysteresis;
    fdj_pkg::fdj_freq_t skip_point_one;
    fdj_pkg::fdj_freq_t skip_point_two;
    fdj_pkg::fdj_freq_t skip_half_width;
    fdj_pkg::fdj_freq_t max_output_frequency;
    logic [15:0]        hold_cycles;
    fdj_pkg::fdj_jump_e js;
    logic [15:0]        hold_cnt;
    fdj_pkg::fdj_freq_t outf;
    fdj_pkg::fdj_freq_t prev_ramp;
    logic               going_up;
  } fdj_top_s;

  fdj_top_s           st;
  fdj_top_s           next_st;
  logic               req;
  fdj_pkg::fdj_freq_t wfreq;
  logic               hit_one;
  logic               hit_two;
  logic               hit;
  logic               ramping;
  fdj_pkg::fdj_freq_t band_lo;
  fdj_pkg::fdj_freq_t band_hi;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic fdj_pkg::fdj_freq_t fdj_merge(input fdj_pkg::fdj_freq_t old, input logic [31:0] dat,
                                                   input logic [3:0] sel);
    fdj_pkg::fdj_freq_t res;
    res = old;
    for (int i = 0; i < fdj_pkg::FREQ_W / 8; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction : fdj_merge

  function automatic fdj_pkg::fdj_freq_t fdj_min(input fdj_pkg::fdj_freq_t a, input fdj_pkg::fdj_freq_t b);
    return (a > b) ? b : a;
  endfunction : fdj_min

  // Widened arithmetic keeps a band near the top of the range from wrapping.
  function automatic logic fdj_in_band(input fdj_pkg::fdj_freq_t f, input fdj_pkg::fdj_freq_t p,
                                       input fdj_pkg::fdj_freq_t a);
    logic [fdj_pkg::FREQ_W:0] fa;
    logic [fdj_pkg::FREQ_W:0] pa;
    fa = {1'b0, f} + {1'b0, a};
    pa = {1'b0, p} + {1'b0, a};
    // A zero point is no band at all.
    return (p != fdj_pkg::FREQ_ZERO) && (fa >= {1'b0, p}) && ({1'b0, f} <= pa);
  endfunction : fdj_in_band

  function automatic fdj_pkg::fdj_freq_t fdj_lo_edge(input fdj_pkg::fdj_freq_t p, input fdj_pkg::fdj_freq_t a);
    return (p > a) ? (p - a) : fdj_pkg::FREQ_ZERO;
  endfunction : fdj_lo_edge

  function automatic fdj_pkg::fdj_freq_t fdj_hi_edge(input fdj_pkg::fdj_freq_t p, input fdj_pkg::fdj_freq_t a);
    logic [fdj_pkg::FREQ_W:0] s;
    s = {1'b0, p} + {1'b0, a};
    return s[fdj_pkg::FREQ_W] ? fdj_pkg::FREQ_SAT : s[fdj_pkg::FREQ_W-1:0];
  endfunction : fdj_hi_edge

  // ****************************************************************
  // Threshold detectors
  // ****************************************************************
  fdj_det_if det_if [fdj_pkg::NUM_DET] ();

  assign det_if[0].level = st.threshold_one_level;
  assign det_if[0].hyst  = st.threshold_one_hysteresis;
  assign det_if[0].freq  = st.outf;
  assign det_if[1].level = st.threshold_two_level;
  assign det_if[1].hyst  = st.threshold_two_hysteresis;
  assign det_if[1].freq  = st.outf;

  // Both detectors watch the frequency actually driven out, not the ramp request.
  generate
    for (genvar g = 0; g < fdj_pkg::NUM_DET; g++) begin : g_det
      fdj_thresh u_thresh (
        .core_clk (core_clk),
        .rstn     (rstn),
        .dif      (det_if[g])
      );
    end
  endgenerate

  assign freq_threshold_one = det_if[0].flag;
  assign freq_threshold_two = det_if[1].flag;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    req     = wb_cyc_i && wb_stb_i && !st.ack;
    wfreq   = fdj_merge(fdj_pkg::FREQ_ZERO, wb_dat_i, wb_sel_i);

    // Bus slave: one wait state, ack for exactly one cycle.
    next_st.ack = req;
    if (req && wb_we_i) begin
      if (wb_adr_i == fdj_pkg::ADR_CTRL) begin
        if (wb_sel_i[0]) begin
          next_st.skip_while_ramping = wb_dat_i[fdj_pkg::CTRL_SKIP_BIT];
        end
      end else if (wb_adr_i == fdj_pkg::ADR_LVL1) begin
        next_st.threshold_one_level =
          fdj_min(fdj_merge(st.threshold_one_level, wb_dat_i, wb_sel_i), st.max_output_frequency);
      end else if (wb_adr_i == fdj_pkg::ADR_HYS1) begin
        next_st.threshold_one_hysteresis =
          fdj_min(fdj_merge(st.threshold_one_hysteresis, wb_dat_i, wb_sel_i), st.threshold_one_level);
      end else if (wb_adr_i == fdj_pkg::ADR_LVL2) begin
        next_st.threshold_two_level =
          fdj_min(fdj_merge(st.threshold_two_level, wb_dat_i, wb_sel_i), st.max_output_frequency);
      end else if (wb_adr_i == fdj_pkg::ADR_HYS2) begin
        next_st.threshold_two_hysteresis =
          fdj_min(fdj_merge(st.threshold_two_hysteresis, wb_dat_i, wb_sel_i), st.threshold_two_level);
      end else if (wb_adr_i == fdj_pkg::ADR_PT1) begin
        next_st.skip_point_one =
          fdj_min(fdj_merge(st.skip_point_one, wb_dat_i, wb_sel_i), st.max_output_frequency);
      end else if (wb_adr_i == fdj_pkg::ADR_PT2) begin
        next_st.skip_point_two =
          fdj_min(fdj_merge(st.skip_point_two, wb_dat_i, wb_sel_i), st.max_output_frequency);
      end else if (wb_adr_i == fdj_pkg::ADR_HALF_W) begin
        next_st.skip_half_width =
          fdj_min(fdj_merge(st.skip_half_width, wb_dat_i, wb_sel_i), fdj_pkg::HALF_W_MAX);
      end else if (wb_adr_i == fdj_pkg::ADR_FMAX) begin
        next_st.max_output_frequency = wfreq;
      end else if (wb_adr_i == fdj_pkg::ADR_HOLD) begin
        // Zero would mean no hold at all, so it is kept at one.
        next_st.hold_cycles = (wfreq == fdj_pkg::FREQ_ZERO) ? fdj_pkg::CNT_ONE : wfreq;
      end
    end

    next_st.rdata = fdj_pkg::DATA_ZERO;
    if (req && !wb_we_i) begin
      if (wb_adr_i == fdj_pkg::ADR_CTRL) begin
        next_st.rdata[fdj_pkg::CTRL_SKIP_BIT] = st.skip_while_ramping;
      end else if (wb_adr_i == fdj_pkg::ADR_LVL1) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0] = st.threshold_one_level;
      end else if (wb_adr_i == fdj_pkg::ADR_HYS1) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0] = st.threshold_one_hysteresis;
      end else if (wb_adr_i == fdj_pkg::ADR_LVL2) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0] = st.threshold_two_level;
      end else if (wb_adr_i == fdj_pkg::ADR_HYS2) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0] = st.threshold_two_hysteresis;
      end else if (wb_adr_i == fdj_pkg::ADR_PT1) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0] = st.skip_point_one;
      end else if (wb_adr_i == fdj_pkg::ADR_PT2) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0] = st.skip_point_two;
      end else if (wb_adr_i == fdj_pkg::ADR_HALF_W) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0] = st.skip_half_width;
      end else if (wb_adr_i == fdj_pkg::ADR_FMAX) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0] = st.max_output_frequency;
      end else if (wb_adr_i == fdj_pkg::ADR_HOLD) begin
        next_st.rdata[15:0] = st.hold_cycles;
      end else if (wb_adr_i == fdj_pkg::ADR_STATUS) begin
        next_st.rdata[fdj_pkg::FREQ_W-1:0]          = st.outf;
        next_st.rdata[fdj_pkg::STAT_FLAG1_BIT]      = det_if[0].flag;
        next_st.rdata[fdj_pkg::STAT_FLAG2_BIT]      = det_if[1].flag;
        next_st.rdata[fdj_pkg::STAT_STATE_LSB +: 2] = st.js;
      end
    end

    // Skip bands; with both points zero no band can be hit.
    hit_one = fdj_in_band(ramp_freq, st.skip_point_one, st.skip_half_width);
    hit_two = fdj_in_band(ramp_freq, st.skip_point_two, st.skip_half_width);
    hit     = hit_one || hit_two;
    band_lo = hit_one ? fdj_lo_edge(st.skip_point_one, st.skip_half_width)
                      : fdj_lo_edge(st.skip_point_two, st.skip_half_width);
    band_hi = hit_one ? fdj_hi_edge(st.skip_point_one, st.skip_half_width)
                      : fdj_hi_edge(st.skip_point_two, st.skip_half_width);
    ramping = (ramp_freq != st.prev_ramp);
    next_st.prev_ramp = ramp_freq;

    case (st.js)
      fdj_pkg::JS_PASS: begin
        if (hit && ramping && st.skip_while_ramping) begin
          // Hold the last output frequency before the band.
          next_st.js       = fdj_pkg::JS_HOLD;
          next_st.hold_cnt = 16'h0000;
          next_st.going_up = (ramp_freq > st.outf);
        end else if (hit && !ramping) begin
          // A steady reference is never left sitting inside a band.
          next_st.outf = band_lo;
        end else begin
          next_st.outf = ramp_freq;
        end
      end
      fdj_pkg::JS_HOLD: begin
        next_st.hold_cnt = st.hold_cnt + fdj_pkg::CNT_ONE;
        if (!hit) begin
          next_st.js   = fdj_pkg::JS_PASS;
          next_st.outf = ramp_freq;
        end else if (next_st.hold_cnt >= st.hold_cycles) begin
          next_st.js = fdj_pkg::JS_SKIP;
        end
      end
      fdj_pkg::JS_SKIP: begin
        if (hit) begin
          next_st.outf = st.going_up ? band_hi : band_lo;
        end else begin
          next_st.js   = fdj_pkg::JS_PASS;
          next_st.outf = ramp_freq;
        end
      end
      default: begin
        next_st.js = fdj_pkg::JS_PASS;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st                          <= '0;
      st.skip_while_ramping       <= fdj_pkg::SKIP_EN_RST;
      st.threshold_one_level      <= fdj_pkg::LEVEL_RST;
      st.threshold_one_hysteresis <= fdj_pkg::HYST_RST;
      st.threshold_two_level      <= fdj_pkg::LEVEL_RST;
      st.threshold_two_hysteresis <= fdj_pkg::HYST_RST;
      st.skip_point_one           <= fdj_pkg::POINT_RST;
      st.skip_point_two           <= fdj_pkg::POINT_RST;
      st.skip_half_width          <= fdj_pkg::HALF_W_RST;
      st.max_output_frequency     <= fdj_pkg::FMAX_RST;
      st.hold_cycles              <= fdj_pkg::HOLD_RST;
      st.js                       <= fdj_pkg::JS_PASS;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign freq_out = st.outf;

endmodule : fdj_top

/* tb/fdj_partner.sv */
// Model of the equipment that reads the two detection output terminals.
// Assumes the flags are levels on core_clk; it counts each activation it sees.
`timescale 1ns/1ps
module fdj_partner (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic freq_threshold_one,
  input  wire logic freq_threshold_two,
  output int        n_on_one,
  output int        n_on_two
);
  logic last_one;
  logic last_two;

  // A relay input only sees edges, so chatter around a level would show as extra counts.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_one <= 1'b0;
      last_two <= 1'b0;
      n_on_one <= 0;
      n_on_two <= 0;
    end else begin
      last_one <= freq_threshold_one;
      last_two <= freq_threshold_two;
      if (freq_threshold_one && !last_one) n_on_one <= n_on_one + 1;
      if (freq_threshold_two && !last_two) n_on_two <= n_on_two + 1;
    end
  end
endmodule : fdj_partner

/* tb/fdj_top_assertions.sv */
// Concurrent checks on the frequency supervision top, seen from its ports only.
// Assumes in-range settings written with all byte enables set, one band used at a time.
`timescale 1ns/1ps
module fdj_top_assertions (
  input wire logic                      core_clk,
  input wire logic                      rstn,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [fdj_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire fdj_pkg::fdj_freq_t        ramp_freq,
  input wire fdj_pkg::fdj_freq_t        freq_out,
  input wire logic                      freq_threshold_one,
  input wire logic                      freq_threshold_two
);
  typedef struct packed {
    logic skip;
    fdj_pkg::fdj_freq_t lvl1, hys1, lvl2, hys2, pt1, pt2, half, fmax;
  } fdj_shadow_s;
  localparam fdj_shadow_s SH_RST = {fdj_pkg::SKIP_EN_RST, fdj_pkg::LEVEL_RST, fdj_pkg::HYST_RST,
    fdj_pkg::LEVEL_RST, fdj_pkg::HYST_RST, fdj_pkg::POINT_RST, fdj_pkg::POINT_RST,
    fdj_pkg::HALF_W_RST, fdj_pkg::FMAX_RST};

  fdj_shadow_s        sh;
  fdj_shadow_s        next_sh;
  fdj_pkg::fdj_freq_t wd;
  fdj_pkg::fdj_freq_t low1;
  fdj_pkg::fdj_freq_t low2;
  logic               in_band;

  assign wd = wb_dat_i[15:0];
  // The release point uses the hysteresis bounded by its level, as the detector does.
  assign low1 = sh.lvl1 - ((sh.hys1 > sh.lvl1) ? sh.lvl1 : sh.hys1);
  assign low2 = sh.lvl2 - ((sh.hys2 > sh.lvl2) ? sh.lvl2 : sh.hys2);
  assign in_band = sh.skip && ((sh.pt1 != 16'h0000 && freq_out > sh.pt1 - sh.half && freq_out < sh.pt1 + sh.half)
    || (sh.pt2 != 16'h0000 && freq_out > sh.pt2 - sh.half && freq_out < sh.pt2 + sh.half));

  always_comb begin
    next_sh = sh;
    if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      case (wb_adr_i)
        fdj_pkg::ADR_CTRL:   next_sh.skip = wb_dat_i[fdj_pkg::CTRL_SKIP_BIT];
        fdj_pkg::ADR_LVL1:   next_sh.lvl1 = (wd > sh.fmax) ? sh.fmax : wd;
        fdj_pkg::ADR_HYS1:   next_sh.hys1 = (wd > sh.lvl1) ? sh.lvl1 : wd;
        fdj_pkg::ADR_LVL2:   next_sh.lvl2 = (wd > sh.fmax) ? sh.fmax : wd;
        fdj_pkg::ADR_HYS2:   next_sh.hys2 = (wd > sh.lvl2) ? sh.lvl2 : wd;
        fdj_pkg::ADR_PT1:    next_sh.pt1 = (wd > sh.fmax) ? sh.fmax : wd;
        fdj_pkg::ADR_PT2:    next_sh.pt2 = (wd > sh.fmax) ? sh.fmax : wd;
        fdj_pkg::ADR_HALF_W: next_sh.half = (wd > fdj_pkg::HALF_W_MAX) ? fdj_pkg::HALF_W_MAX : wd;
        fdj_pkg::ADR_FMAX:   next_sh.fmax = wd;
        default:             ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) sh <= SH_RST;
    else sh <= next_sh;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_ack_after_request;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_after_request: assert property (p_ack_after_request) else $error("ack missing after a request");
  property p_ack_single;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
  property p_dat_idle_zero;
    !wb_ack_o |-> wb_dat_o == fdj_pkg::DATA_ZERO;
  endproperty
  a_dat_idle_zero: assert property (p_dat_idle_zero) else $error("read data not zero outside ack");
  property p_one_rise;
    $rose(freq_threshold_one) |-> $past(freq_out) > sh.lvl1;
  endproperty
  a_one_rise: assert property (p_one_rise) else $error("flag one rose at or below its level");
  property p_one_set;
    !freq_threshold_one && freq_out > sh.lvl1 |=> freq_threshold_one;
  endproperty
  a_one_set: assert property (p_one_set) else $error("flag one did not rise above its level");
  property p_one_fall;
    $fell(freq_threshold_one) |-> $past(freq_out) < low1;
  endproperty
  a_one_fall: assert property (p_one_fall) else $error("flag one fell inside hysteresis");
  property p_two_rise;
    $rose(freq_threshold_two) |-> $past(freq_out) > sh.lvl2;
  endproperty
  a_two_rise: assert property (p_two_rise) else $error("flag two rose at or below its level");
  property p_two_fall;
    $fell(freq_threshold_two) |-> $past(freq_out) < low2;
  endproperty
  a_two_fall: assert property (p_two_fall) else $error("flag two fell inside hysteresis");
  property p_follow_no_skip;
    !sh.skip && ramp_freq != $past(ramp_freq) |=> freq_out == $past(ramp_freq);
  endproperty
  a_follow_no_skip: assert property (p_follow_no_skip) else $error("ramp not passed through");
  property p_follow_no_points;
    sh.pt1 == 16'h0000 && sh.pt2 == 16'h0000 |=> freq_out == $past(ramp_freq);
  endproperty
  a_follow_no_points: assert property (p_follow_no_points) else $error("output differs with skip off");
  property p_no_band_interior;
    !in_band;
  endproperty
  a_no_band_interior: assert property (p_no_band_interior) else $error("output inside a band");
endmodule : fdj_top_assertions

bind fdj_top fdj_top_assertions u_chk (.*);

/* tb/fdj_top_test.sv */
// Self-checking bench of the frequency supervision top: registers, flags and skip bands.
// Assumes the design answers every Wishbone request; waits are bounded all the same.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module fdj_top_test;
  logic               core_clk  = 1'b0;
  logic               rstn      = 1'b0;
  logic               wb_cyc_i  = 1'b0;
  logic               wb_stb_i  = 1'b0;
  logic               wb_we_i   = 1'b0;
  logic [7:0]         wb_adr_i  = 8'h00;
  logic [31:0]        wb_dat_i  = 32'h0000_0000;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  fdj_pkg::fdj_freq_t ramp_freq = 16'h0000;
  fdj_pkg::fdj_freq_t freq_out;
  logic               freq_threshold_one;
  logic               freq_threshold_two;
  int                 n_on_one;
  int                 n_on_two;
  int                 n_errors  = 0;
  int                 n_compared = 0;

  fdj_top dut (.*, .wb_sel_i(4'hF));
  fdj_partner u_partner (.*);

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Bus and stimulus helpers
  // ****************************************************************
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wdat;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    `CHK("bus ack", 1'b1, wb_ack_o)
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_cycle
  task automatic wb_write(input logic [7:0] adr, input logic [31:0] wdat);
    logic [31:0] d;
    wb_cycle(1'b1, adr, wdat, d);
  endtask : wb_write
  task automatic check_reg(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb_cycle(1'b0, adr, 32'h0000_0000, d);
    `CHK(what, exp, d)
  endtask : check_reg
  task automatic set_ramp(input fdj_pkg::fdj_freq_t v, input int n);
    @(posedge core_clk);
    ramp_freq <= v;
    repeat (n) @(posedge core_clk);
  endtask : set_ramp

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values();
    logic [15:0] e [10] = '{16'h0000, 16'h1388, 16'h00FA, 16'h1388, 16'h00FA,
      16'h0000, 16'h0000, 16'h0000, 16'h1388, 16'h01F4};
    for (int i = 0; i < 10; i++) begin
      check_reg("reset value", 8'(i * 4), {16'h0000, e[i]});
    end
  endtask : t_reset_values
  task automatic t_thresholds();
    logic [15:0] f [8] = '{16'h0BB8, 16'h0BB9, 16'h1388, 16'h1389, 16'h128E, 16'h128D, 16'h0B54, 16'h0B53};
    logic [7:0] e1 = 8'h18;
    logic [7:0] e2 = 8'h7E;
    wb_write(8'h0C, 32'h0000_0BB8);
    wb_write(8'h10, 32'h0000_0064);
    for (int i = 0; i < 8; i++) begin
      set_ramp(f[i], 3);
      `CHK("output frequency", f[i], freq_out)
      `CHK("flag one", e1[i], freq_threshold_one)
      `CHK("flag two", e2[i], freq_threshold_two)
    end
    `CHK("flag one activations", 1, n_on_one)
    `CHK("flag two activations", 1, n_on_two)
  endtask : t_thresholds
  task automatic t_clamps();
    wb_write(8'h04, 32'h0000_1770);
    check_reg("level clamp", 8'h04, 32'h0000_1388);
    wb_write(8'h08, 32'h0000_1770);
    check_reg("hysteresis clamp", 8'h08, 32'h0000_1388);
    wb_write(8'h08, 32'h0000_00FA);
    wb_write(8'h1C, 32'h0000_0258);
    check_reg("half width clamp", 8'h1C, 32'h0000_01F4);
    wb_write(8'h24, 32'h0000_0000);
    check_reg("hold floor", 8'h24, 32'h0000_0001);
    wb_write(8'h40, 32'h0000_1234);
    check_reg("unmapped read", 8'h40, 32'h0000_0000);
  endtask : t_clamps
  task automatic t_skip(input logic [7:0] adr);
    wb_write(adr, 32'h0000_07D0);
    set_ramp(16'h073A, 3);
    set_ramp(16'h079E, 2);
    `CHK("held rising", 16'h073A, freq_out)
    repeat (10) @(posedge core_clk);
    `CHK("upper edge", 16'h0834, freq_out)
    check_reg("status in skip", 8'h28, 32'h0008_0834);
    set_ramp(16'h0898, 3);
    `CHK("above band", 16'h0898, freq_out)
    set_ramp(16'h0802, 2);
    `CHK("held falling", 16'h0898, freq_out)
    repeat (10) @(posedge core_clk);
    `CHK("lower edge", 16'h076C, freq_out)
    set_ramp(16'h06A4, 3);
    wb_write(adr, 32'h0000_0000);
  endtask : t_skip
  task automatic t_ramp_through();
    fdj_pkg::fdj_freq_t x;
    x = 16'h0708;
    wb_write(8'h00, 32'h0000_0000);
    wb_write(8'h14, 32'h0000_07D0);
    for (int i = 0; i <= 20; i++) begin
      @(posedge core_clk);
      if (i >= 2) begin
        `CHK("ramp through band", x, freq_out)
        x = x + 16'h0014;
      end
      ramp_freq <= 16'h0708 + 16'(i * 20);
    end
  endtask : t_ramp_through

  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset_values();
    t_thresholds();
    t_clamps();
    wb_write(8'h1C, 32'h0000_0064);
    wb_write(8'h24, 32'h0000_0004);
    wb_write(8'h00, 32'h0000_0001);
    t_skip(8'h14);
    t_skip(8'h18);
    t_ramp_through();
    test_done();
  end

  // The whole run takes well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
endmodule : fdj_top_test
